//--- common/mss_if.sv
// Interfaces between the sequencer and its timer and limit filter
interface mss_tick_if;
    logic              restart;
    mss_pkg::mss_time_t elapsed;
    modport master (output restart, input elapsed);
    modport timer  (input restart, output elapsed);
endinterface : mss_tick_if

interface mss_lim_if;
    logic [1:0] filterCode;
    logic       limitTrip;
    logic       shutdownTrip;
    modport master (output filterCode, input limitTrip, shutdownTrip);
    modport filter (input filterCode, output limitTrip, shutdownTrip);
endinterface : mss_lim_if

//--- common/mss_pkg.sv
// Constants, register map and decode functions of the motor startup sequencer
package mss_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_STARTUP_CURRENT = 8'h10;
    localparam logic [7:0] ADDR_BRAKE           = 8'h13;
    localparam logic [7:0] ADDR_DC_EXCITATION   = 8'h14;
    localparam logic [7:0] ADDR_FORCED_COMM     = 8'h15;
    localparam logic [7:0] ADDR_LIMIT_LEVEL     = 8'h17;
    localparam logic [7:0] ADDR_HYSTERESIS      = 8'h18;
    localparam logic [7:0] ADDR_FILTER          = 8'h0f;
    // Field positions
    localparam int STARTUP_FRACTION_LSB = 1;
    localparam int BRAKE_SECONDS_LSB    = 0;
    localparam int BRAKE_FET_BIT        = 4;
    localparam int BRAKE_HOLD_BIT       = 3;
    localparam int FIRST_EXC_LSB        = 3;
    localparam int SECOND_EXC_LSB       = 0;
    localparam int FORCED_RATE_LSB      = 0;
    localparam int LIMIT_SELECT_BIT     = 6;
    localparam int HYSTERESIS_LSB       = 6;
    localparam int FILTER_LSB           = 0;
    // Values after reset
    localparam logic [7:0] REG_RESET = 8'h00;
    // Timing
    localparam int CLK_MHZ          = 200;
    localparam int TICK_US          = 100;
    localparam int TICK_CYCLES      = CLK_MHZ * TICK_US;
    localparam int SECOND_US        = 1000000;
    localparam int MS_US            = 1000;
    localparam int STEPS_PER_CYCLE  = 6;
    localparam int TIME_WIDTH       = 17;
    localparam int FORCED_STEPS     = 12;
    localparam int FRACTION_FULL    = 8;

    typedef logic [TIME_WIDTH-1:0] mss_time_t;

    typedef enum logic [3:0] {
        SEQ_WAIT   = 4'h0,
        SEQ_BRAKE  = 4'h1,
        SEQ_HOLD   = 4'h2,
        SEQ_IDLE   = 4'h3,
        SEQ_DETECT = 4'h4,
        SEQ_EXC1   = 4'h5,
        SEQ_EXC2   = 4'h6,
        SEQ_FORCED = 4'h7,
        SEQ_RUN    = 4'h8,
        SEQ_ERROR  = 4'h9
    } mss_state_e;

    // Microseconds to ticks
    function automatic mss_time_t usToTicks(input int us);
        usToTicks = mss_time_t'(us / TICK_US);
    endfunction : usToTicks

    // First excitation length: 0, 0.2, 0.5, 1.0 s
    function automatic mss_time_t firstExcTicks(input logic [1:0] code);
        unique case (code)
            2'h0: firstExcTicks = usToTicks(0);
            2'h1: firstExcTicks = usToTicks(200 * MS_US);
            2'h2: firstExcTicks = usToTicks(500 * MS_US);
            2'h3: firstExcTicks = usToTicks(1000 * MS_US);
        endcase
    endfunction : firstExcTicks

    // Second excitation length: 0.1 to 2 s
    function automatic mss_time_t secondExcTicks(input logic [2:0] code);
        unique case (code)
            3'h0: secondExcTicks = usToTicks(100 * MS_US);
            3'h1: secondExcTicks = usToTicks(200 * MS_US);
            3'h2: secondExcTicks = usToTicks(400 * MS_US);
            3'h3: secondExcTicks = usToTicks(600 * MS_US);
            3'h4: secondExcTicks = usToTicks(800 * MS_US);
            3'h5: secondExcTicks = usToTicks(1000 * MS_US);
            3'h6: secondExcTicks = usToTicks(1500 * MS_US);
            3'h7: secondExcTicks = usToTicks(2000 * MS_US);
        endcase
    endfunction : secondExcTicks

    // Forced step length: one sixth of the period of 1.6, 3.2, 6.4, 12.8 Hz
    function automatic mss_time_t forcedStepTicks(input logic [1:0] code);
        unique case (code)
            2'h0: forcedStepTicks = usToTicks(625000 / STEPS_PER_CYCLE);
            2'h1: forcedStepTicks = usToTicks(312500 / STEPS_PER_CYCLE);
            2'h2: forcedStepTicks = usToTicks(156250 / STEPS_PER_CYCLE);
            2'h3: forcedStepTicks = usToTicks(78125 / STEPS_PER_CYCLE);
        endcase
    endfunction : forcedStepTicks

    // Spin detection window: 200, 100, 50, 25 ms
    function automatic mss_time_t detectTicks(input logic [1:0] code);
        unique case (code)
            2'h0: detectTicks = usToTicks(200 * MS_US);
            2'h1: detectTicks = usToTicks(100 * MS_US);
            2'h2: detectTicks = usToTicks(50 * MS_US);
            2'h3: detectTicks = usToTicks(25 * MS_US);
        endcase
    endfunction : detectTicks

    // Six-step bridge pattern {high[2:0], low[2:0]}, phases W V U
    function automatic logic [5:0] commPattern(input logic [2:0] step);
        unique case (step)
            3'h0:    commPattern = 6'b001_010;
            3'h1:    commPattern = 6'b001_100;
            3'h2:    commPattern = 6'b010_100;
            3'h3:    commPattern = 6'b010_001;
            3'h4:    commPattern = 6'b100_001;
            3'h5:    commPattern = 6'b100_010;
            default: commPattern = 6'b000_000;
        endcase
    endfunction : commPattern
endpackage : mss_pkg

//--- core/mss_limit_filter.sv
// Synchroniser and digital noise filter for the current-limit comparator
module mss_limit_filter (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic compHigh,
    mss_lim_if.filter lim
);
    logic [2:0] syncQ, syncD;
    logic       stableQ, stableD;
    logic [3:0] runQ, runD;
    logic [3:0] limitNeed;

    // Clocks of agreement needed: limit 0/4/6/7, shutdown one more
    always_comb begin
        unique case (lim.filterCode)
            2'h0: limitNeed = 4'h0;
            2'h1: limitNeed = 4'h4;
            2'h2: limitNeed = 4'h6;
            2'h3: limitNeed = 4'h7;
        endcase
    end

    // Stable level moves only when stages two and three agree
    always_comb begin
        syncD   = {syncQ[1:0], compHigh};
        stableD = (syncQ[1] == syncQ[2]) ? syncQ[2] : stableQ;
        // Run counts clocks after the stable level rose, so code 00 trips the limit one clock before shutdown
        runD    = !stableQ ? 4'h0 : (runQ == 4'hf ? runQ : runQ + 4'h1);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            syncQ   <= 3'h0;
            stableQ <= 1'b0;
            runQ    <= 4'h0;
        end else begin
            syncQ   <= syncD;
            stableQ <= stableD;
            runQ    <= runD;
        end
    end

    // Code 00 acts at once on the stable level
    assign lim.limitTrip    = stableQ && (runQ >= limitNeed);
    assign lim.shutdownTrip = stableQ && (runQ >= limitNeed + 4'h1);
endmodule : mss_limit_filter

//--- core/mss_motor_startup_sequencer.sv
// Brake, idle and startup sequencer with cycle-by-cycle output current limit
module mss_motor_startup_sequencer #(
    parameter int TICK_CYCLES  = mss_pkg::TICK_CYCLES,
    parameter int FORCED_STEPS = mss_pkg::FORCED_STEPS
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    input  wire logic       settingsLoaded,
    input  wire logic       speedCmd,
    input  wire logic       errorStop,
    input  wire logic       spinForward,
    input  wire logic       pwmOn,
    input  wire logic       pwmPeriodStart,
    input  wire logic [2:0] senseStep,
    input  wire logic       limitCompHigh,
    output logic      [2:0] gateHigh,
    output logic      [2:0] gateLow,
    output logic      [1:0] hysteresisSel,
    output logic            limitThresholdSel,
    output logic      [3:0] limitFractionEighths,
    output logic            overcurrentShutdown,
    output logic      [3:0] seqState
);
    mss_tick_if tick ();
    mss_lim_if  lim ();

    // Register storage
    logic [7:0] startupCfgQ, startupCfgD;
    logic [7:0] brakeCfgQ, brakeCfgD;
    logic [7:0] excCfgQ, excCfgD;
    logic [7:0] forcedCfgQ, forcedCfgD;
    logic [7:0] levelCfgQ, levelCfgD;
    logic [7:0] hysCfgQ, hysCfgD;
    logic [7:0] filterCfgQ, filterCfgD;
    logic [7:0] rdDataQ, rdDataD;

    // Sequencer state
    mss_pkg::mss_state_e stateQ, stateD;
    logic [2:0]          stepQ, stepD;
    logic [4:0]          stepCountQ, stepCountD;
    logic                stepAdvance;
    logic [2:0]          spinSyncQ, spinSyncD;
    logic                spinStableQ, spinStableD;
    logic                limitOffQ, limitOffD;
    logic [5:0]          gateQ, gateD;
    logic                shutdownQ, shutdownD;

    // Decoded fields
    logic [2:0]          brakeSeconds;
    logic                brakeShort;
    logic                brakeHold;
    mss_pkg::mss_time_t  brakeTicks;
    mss_pkg::mss_time_t  exc1Ticks;
    mss_pkg::mss_time_t  exc2Ticks;
    mss_pkg::mss_time_t  stepTicks;
    mss_pkg::mss_time_t  windowTicks;
    logic                inStartup;
    logic [5:0]          pattern;

    assign brakeSeconds = brakeCfgQ[mss_pkg::BRAKE_SECONDS_LSB +: 3];
    assign brakeShort   = brakeCfgQ[mss_pkg::BRAKE_FET_BIT];
    assign brakeHold    = brakeCfgQ[mss_pkg::BRAKE_HOLD_BIT];
    assign brakeTicks   = mss_pkg::mss_time_t'(brakeSeconds)
                          * mss_pkg::usToTicks(mss_pkg::SECOND_US);
    assign exc1Ticks    = mss_pkg::firstExcTicks(excCfgQ[mss_pkg::FIRST_EXC_LSB +: 2]);
    assign exc2Ticks    = mss_pkg::secondExcTicks(excCfgQ[mss_pkg::SECOND_EXC_LSB +: 3]);
    assign stepTicks    = mss_pkg::forcedStepTicks(forcedCfgQ[mss_pkg::FORCED_RATE_LSB +: 2]);
    assign windowTicks  = mss_pkg::detectTicks(forcedCfgQ[mss_pkg::FORCED_RATE_LSB +: 2]);

    mss_tick_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    mss_limit_filter u_filter (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .compHigh (limitCompHigh),
        .lim      (lim)
    );

    // Register writes and registered read data; unmapped reads return zero
    always_comb begin
        startupCfgD = startupCfgQ;
        brakeCfgD   = brakeCfgQ;
        excCfgD     = excCfgQ;
        forcedCfgD  = forcedCfgQ;
        levelCfgD   = levelCfgQ;
        hysCfgD     = hysCfgQ;
        filterCfgD  = filterCfgQ;
        rdDataD     = rdDataQ;
        if (regWrEn) begin
            unique case (regAddr)
                mss_pkg::ADDR_STARTUP_CURRENT: startupCfgD = regWrData;
                mss_pkg::ADDR_BRAKE:           brakeCfgD   = regWrData;
                mss_pkg::ADDR_DC_EXCITATION:   excCfgD     = regWrData;
                mss_pkg::ADDR_FORCED_COMM:     forcedCfgD  = regWrData;
                mss_pkg::ADDR_LIMIT_LEVEL:     levelCfgD   = regWrData;
                mss_pkg::ADDR_HYSTERESIS:      hysCfgD     = regWrData;
                mss_pkg::ADDR_FILTER:          filterCfgD  = regWrData;
                default:                       ;
            endcase
        end
        if (regRdEn) begin
            unique case (regAddr)
                mss_pkg::ADDR_STARTUP_CURRENT: rdDataD = startupCfgQ;
                mss_pkg::ADDR_BRAKE:           rdDataD = brakeCfgQ;
                mss_pkg::ADDR_DC_EXCITATION:   rdDataD = excCfgQ;
                mss_pkg::ADDR_FORCED_COMM:     rdDataD = forcedCfgQ;
                mss_pkg::ADDR_LIMIT_LEVEL:     rdDataD = levelCfgQ;
                mss_pkg::ADDR_HYSTERESIS:      rdDataD = hysCfgQ;
                mss_pkg::ADDR_FILTER:          rdDataD = filterCfgQ;
                default:                       rdDataD = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            startupCfgQ <= mss_pkg::REG_RESET;
            brakeCfgQ   <= mss_pkg::REG_RESET;
            excCfgQ     <= mss_pkg::REG_RESET;
            forcedCfgQ  <= mss_pkg::REG_RESET;
            levelCfgQ   <= mss_pkg::REG_RESET;
            hysCfgQ     <= mss_pkg::REG_RESET;
            filterCfgQ  <= mss_pkg::REG_RESET;
            rdDataQ     <= 8'h00;
        end else begin
            startupCfgQ <= startupCfgD;
            brakeCfgQ   <= brakeCfgD;
            excCfgQ     <= excCfgD;
            forcedCfgQ  <= forcedCfgD;
            levelCfgQ   <= levelCfgD;
            hysCfgQ     <= hysCfgD;
            filterCfgQ  <= filterCfgD;
            rdDataQ     <= rdDataD;
        end
    end

    // Forward-spin indication from the position comparator, three-stage sync
    always_comb begin
        spinSyncD   = {spinSyncQ[1:0], spinForward};
        spinStableD = (spinSyncQ[1] == spinSyncQ[2]) ? spinSyncQ[2] : spinStableQ;
    end

    // Mode sequencing; the timer restarts on every change of mode or step
    always_comb begin
        stateD      = stateQ;
        stepAdvance = 1'b0;
        unique case (stateQ)
            mss_pkg::SEQ_WAIT: begin
                if (settingsLoaded) stateD = mss_pkg::SEQ_BRAKE;
            end
            mss_pkg::SEQ_BRAKE: begin
                if (tick.elapsed >= brakeTicks) begin
                    if (brakeHold && brakeSeconds != 3'h0) stateD = mss_pkg::SEQ_HOLD;
                    else stateD = mss_pkg::SEQ_IDLE;
                end
            end
            mss_pkg::SEQ_HOLD: begin
                if (speedCmd) stateD = mss_pkg::SEQ_DETECT;
            end
            mss_pkg::SEQ_IDLE: begin
                if (speedCmd) stateD = mss_pkg::SEQ_DETECT;
            end
            mss_pkg::SEQ_DETECT: begin
                if (spinStableQ) stateD = mss_pkg::SEQ_RUN;
                else if (tick.elapsed >= windowTicks) stateD = mss_pkg::SEQ_EXC1;
            end
            mss_pkg::SEQ_EXC1: begin
                if (tick.elapsed >= exc1Ticks) stateD = mss_pkg::SEQ_EXC2;
            end
            mss_pkg::SEQ_EXC2: begin
                if (tick.elapsed >= exc2Ticks) stateD = mss_pkg::SEQ_FORCED;
            end
            mss_pkg::SEQ_FORCED: begin
                if (tick.elapsed >= stepTicks) begin
                    stepAdvance = 1'b1;
                    if (stepCountQ == 5'(FORCED_STEPS - 1)) stateD = mss_pkg::SEQ_RUN;
                end
            end
            mss_pkg::SEQ_RUN:   ;
            mss_pkg::SEQ_ERROR: begin
                if (!errorStop && speedCmd) stateD = mss_pkg::SEQ_DETECT;
            end
            default: stateD = mss_pkg::SEQ_IDLE;
        endcase
        if (stateQ >= mss_pkg::SEQ_DETECT && stateQ != mss_pkg::SEQ_ERROR && errorStop) begin
            stateD = mss_pkg::SEQ_ERROR;
        end
        if (stateQ >= mss_pkg::SEQ_DETECT && !speedCmd) begin
            stateD = mss_pkg::SEQ_IDLE;
        end
        tick.restart = (stateD != stateQ) || stepAdvance;
    end

    // Forced commutation step and step count
    always_comb begin
        stepD      = stepQ;
        stepCountD = stepCountQ;
        if (stateQ != mss_pkg::SEQ_FORCED) begin
            stepD      = 3'h0;
            stepCountD = 5'h00;
        end else if (stepAdvance) begin
            stepD      = (stepQ == 3'h5) ? 3'h0 : stepQ + 3'h1;
            stepCountD = stepCountQ + 5'h01;
        end
    end

    // Limit latch: set by the filtered trip, released at each PWM period start
    always_comb begin
        limitOffD = limitOffQ;
        if (pwmPeriodStart) limitOffD = 1'b0;
        if (lim.limitTrip) limitOffD = 1'b1;
        shutdownD = lim.shutdownTrip;
    end

    // Bridge drive pattern for the present mode
    always_comb begin
        inStartup = (stateQ >= mss_pkg::SEQ_DETECT) && (stateQ <= mss_pkg::SEQ_FORCED);
        pattern   = 6'b000_000;
        unique case (stateQ)
            mss_pkg::SEQ_BRAKE,
            mss_pkg::SEQ_HOLD:   pattern = brakeShort ? 6'b000_111 : 6'b000_000;
            mss_pkg::SEQ_EXC1:   pattern = mss_pkg::commPattern(3'h0);
            mss_pkg::SEQ_EXC2:   pattern = mss_pkg::commPattern(3'h1);
            mss_pkg::SEQ_FORCED: pattern = mss_pkg::commPattern(stepQ);
            mss_pkg::SEQ_RUN:    pattern = mss_pkg::commPattern(senseStep);
            default:             pattern = 6'b000_000;
        endcase
        gateD = pattern;
        if (stateQ >= mss_pkg::SEQ_EXC1 && stateQ <= mss_pkg::SEQ_RUN
            && (!pwmOn || limitOffD)) begin
            gateD[5:3] = 3'b000;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stateQ      <= mss_pkg::SEQ_WAIT;
            stepQ       <= 3'h0;
            stepCountQ  <= 5'h00;
            spinSyncQ   <= 3'h0;
            spinStableQ <= 1'b0;
            limitOffQ   <= 1'b0;
            gateQ       <= 6'b000_000;
            shutdownQ   <= 1'b0;
        end else begin
            stateQ      <= stateD;
            stepQ       <= stepD;
            stepCountQ  <= stepCountD;
            spinSyncQ   <= spinSyncD;
            spinStableQ <= spinStableD;
            limitOffQ   <= limitOffD;
            gateQ       <= gateD;
            shutdownQ   <= shutdownD;
        end
    end

    // Filter length and threshold selection to the analog side
    assign lim.filterCode        = filterCfgQ[mss_pkg::FILTER_LSB +: 2];
    assign limitThresholdSel     = levelCfgQ[mss_pkg::LIMIT_SELECT_BIT];
    assign limitFractionEighths  = inStartup
        ? 4'(mss_pkg::FRACTION_FULL) - {1'b0, startupCfgQ[mss_pkg::STARTUP_FRACTION_LSB +: 3]}
        : 4'(mss_pkg::FRACTION_FULL);
    assign hysteresisSel = (stateQ == mss_pkg::SEQ_DETECT)
        ? hysCfgQ[mss_pkg::HYSTERESIS_LSB +: 2] : 2'h0;
    assign gateHigh            = gateQ[5:3];
    assign gateLow             = gateQ[2:0];
    assign overcurrentShutdown = shutdownQ;
    assign regRdData           = rdDataQ;
    assign seqState            = stateQ;
endmodule : mss_motor_startup_sequencer

//--- core/mss_tick_timer.sv
// Prescaled sequence timer counting 100 us ticks since the last restart
module mss_tick_timer #(
    parameter int TICK_CYCLES = mss_pkg::TICK_CYCLES
) (
    input  wire logic  clk,
    input  wire logic  sys_rst,
    mss_tick_if.timer  tick
);
    logic [15:0]        preQ, preD;
    mss_pkg::mss_time_t elapsedQ, elapsedD;

    // Prescaler and saturating tick count, both cleared on restart
    always_comb begin
        preD     = preQ + 16'h0001;
        elapsedD = elapsedQ;
        if (tick.restart) begin
            preD     = 16'h0000;
            elapsedD = '0;
        end else if (preQ == 16'(TICK_CYCLES - 1)) begin
            preD = 16'h0000;
            if (elapsedQ != '1) elapsedD = elapsedQ + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            preQ     <= 16'h0000;
            elapsedQ <= '0;
        end else begin
            preQ     <= preD;
            elapsedQ <= elapsedD;
        end
    end

    assign tick.elapsed = elapsedQ;
endmodule : mss_tick_timer

//--- sim/mss_bridge_model.sv
// Model of the external bridge and shunt comparator facing the sequencer
module mss_bridge_model (
    input  wire logic [2:0] gateHigh,
    input  wire logic [2:0] gateLow,
    input  wire logic       overload,
    output logic            compHigh,
    output logic            shoot
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shunt current only flows while some high side conducts
    assign compHigh = overload && (gateHigh != 3'h0);
    // Both transistors of one leg on would short the supply
    assign shoot = (gateHigh & gateLow) != 3'h0;
endmodule : mss_bridge_model

//--- sim/mss_motor_startup_sequencer_tb.sv
// Self-checking testbench of the motor startup sequencer
module mss_motor_startup_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 0, sys_rst = 1, regWrEn = 0, regRdEn = 0, settingsLoaded = 0, speedCmd = 0;
    logic       errorStop = 0, spinForward = 0, pwmOn = 1, pwmPeriodStart = 0, overload = 0;
    logic       limitCompHigh, shoot, limitThresholdSel, overcurrentShutdown;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rdv;
    logic [2:0] senseStep = 3'h0, gateHigh, gateLow, f;
    logic [1:0] hysteresisSel, h;
    logic [3:0] limitFractionEighths, seqState;
    logic [31:0] seed = 32'h0000_0359, v;
    logic [7:0] regs [7] = '{8'h0f, 8'h10, 8'h13, 8'h14, 8'h15, 8'h17, 8'h18};
    int         n_fail = 0, samples_checked = 0, cyc = 0, n;
    mss_motor_startup_sequencer #(.TICK_CYCLES(4), .FORCED_STEPS(2)) DUT (.clk, .sys_rst, .regWrEn, .regRdEn,
        .regAddr, .regWrData, .regRdData, .settingsLoaded, .speedCmd, .errorStop, .spinForward, .pwmOn,
        .pwmPeriodStart, .senseStep, .limitCompHigh, .gateHigh, .gateLow, .hysteresisSel, .limitThresholdSel,
        .limitFractionEighths, .overcurrentShutdown, .seqState);
    mss_bridge_model u_bridge (.gateHigh, .gateLow, .overload, .compHigh(limitCompHigh), .shoot);
    // Clock and hang guard
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // Xorshift source of random settings
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Startup threshold in eighths for a fraction code
    function automatic logic [3:0] expFrac(input logic [2:0] c);
        return 4'h8 - {1'b0, c};
    endfunction : expFrac
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) {regWrEn, regAddr, regWrData} = {1'b1, a, d};
        @(negedge clk) regWrEn = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge clk) {regRdEn, regAddr} = {1'b1, a};
        @(negedge clk) regRdEn = 0;
        rdv = regRdData;
    endtask : rd
    // Waits a bounded time for a state, leaving the cycles spent in n
    task automatic wt(input logic [3:0] s, input int lim);
        n = 0;
        while (seqState !== s && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk(seqState, s);
    endtask : wt
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial begin
        repeat (5) @(negedge clk);
        sys_rst = 0;
        foreach (regs[i]) begin
            rd(regs[i]);
            chk(rdv, 8'h00);
            v = xs();
            wr(regs[i], v[7:0]);
            rd(regs[i]);
            chk(rdv, v[7:0]);
        end
        wr(8'h20, 8'h5a);
        rd(8'h20);
        chk(rdv, 8'h00);
        $display("test registers done");
        v = xs();
        {h, f} = v[4:0];
        wr(8'h13, 8'h18);
        wr(8'h14, 8'h00);
        wr(8'h15, 8'h03);
        wr(8'h10, {4'h0, f, 1'b0});
        wr(8'h18, {h, 6'h00});
        wr(8'h0f, 8'h00);
        wr(8'h17, 8'h40);
        chk(limitThresholdSel, 1'b1);
        settingsLoaded = 1;
        wt(4'h3, 20);
        @(negedge clk) chk(gateLow | gateHigh, 3'h0);
        speedCmd = 1;
        wt(4'h4, 4);
        chk(hysteresisSel, h);
        wt(4'h6, 1300);
        chk(n >= 1000 && n <= 1012, 1);
        chk(limitFractionEighths, expFrac(f));
        wt(4'h7, 4100);
        chk(n >= 3996 && n <= 4008, 1);
        wt(4'h8, 1200);
        chk(n >= 1036 && n <= 1048, 1);
        repeat (3) @(negedge clk);
        chk(gateHigh, 3'h1);
        chk(limitFractionEighths, 4'h8);
        overload = 1;
        repeat (7) @(negedge clk);
        chk(overcurrentShutdown, 1'b1);
        repeat (5) @(negedge clk);
        chk(gateHigh, 3'h0);
        overload = 0;
        repeat (3) @(negedge clk);
        chk(gateHigh, 3'h0);
        chk(overcurrentShutdown, 1'b0);
        pwmPeriodStart = 1;
        @(negedge clk) pwmPeriodStart = 0;
        @(negedge clk) chk(gateHigh, 3'h1);
        pwmOn = 0;
        @(negedge clk) chk(gateHigh, 3'h0);
        pwmOn = 1;
        chk(shoot, 1'b0);
        speedCmd = 0;
        wt(4'h3, 3);
        $display("test startup done");
        spinForward = 1;
        speedCmd = 1;
        wt(4'h8, 1100);
        errorStop = 1;
        wt(4'h9, 3);
        speedCmd = 0;
        wt(4'h3, 3);
        errorStop = 0;
        spinForward = 0;
        $display("test spinning done");
        sys_rst = 1;
        settingsLoaded = 0;
        repeat (5) @(negedge clk);
        sys_rst = 0;
        wr(8'h13, 8'h19);
        settingsLoaded = 1;
        wt(4'h1, 3);
        wt(4'h2, 40100);
        chk(n >= 39990 && n <= 40010, 1);
        chk(gateLow, 3'h7);
        speedCmd = 1;
        wt(4'h4, 3);
        $display("test brake hold done");
        tally_and_finish();
    end
endmodule : mss_motor_startup_sequencer_tb

//--- sim/mss_props.sv
// Port checker of the motor startup sequencer
module mss_props (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       settingsLoaded,
    input wire logic       speedCmd,
    input wire logic [2:0] gateHigh,
    input wire logic [2:0] gateLow,
    input wire logic [1:0] hysteresisSel,
    input wire logic [3:0] limitFractionEighths,
    input wire logic [3:0] seqState
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Mode transitions, bridge states and threshold selection
    AST_IDLE_OFF: assert property ((seqState == 4'h3 && $past(seqState) == 4'h3) |-> (gateHigh | gateLow) == 3'h0)
        else $error("bridge not off in idle");
    AST_IDLE_GO: assert property ((seqState == 4'h3 && speedCmd) |=> seqState == 4'h4)
        else $error("idle ignored speed command");
    AST_CMD_DROP: assert property ((seqState >= 4'h4 && !speedCmd) |=> seqState == 4'h3)
        else $error("no idle after command removal");
    AST_WAIT_GO: assert property ((seqState == 4'h0 && settingsLoaded) |=> seqState == 4'h1)
        else $error("brake did not follow settings load");
    AST_BRAKE_GATES: assert property ((seqState == 4'h1 && $past(seqState) == 4'h1) |-> gateHigh == 3'h0 && gateLow inside {3'h0, 3'h7})
        else $error("bad bridge state in brake");
    AST_RUN_ENTRY: assert property ((seqState == 4'h8 && $past(seqState) != 4'h8) |-> $past(seqState) inside {4'h4, 4'h7})
        else $error("run entered from wrong state");
    AST_EXC_ORDER: assert property (seqState == 4'h5 |=> seqState inside {4'h5, 4'h6, 4'h3, 4'h9})
        else $error("first excitation left wrongly");
    AST_HYS: assert property (seqState != 4'h4 |-> hysteresisSel == 2'h0)
        else $error("hysteresis outside detection");
    AST_FRAC: assert property (seqState inside {4'h3, 4'h8} |-> limitFractionEighths == 4'h8)
        else $error("startup threshold outside startup");
    // Main scenarios reached
    cover property (seqState == 4'h2);
    cover property (seqState == 4'h8 && $past(seqState) == 4'h4);
    cover property (seqState == 4'h7);
endmodule : mss_props

bind mss_motor_startup_sequencer mss_props u_props (.clk, .sys_rst, .settingsLoaded, .speedCmd, .gateHigh, .gateLow,
    .hysteresisSel, .limitFractionEighths, .seqState);
